// >>> src/fpc_ctl_store.v
// Control store: wide control word and host microinstruction per microaddress
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defs.vh"
module fpc_ctl_store
(
  input  wire [`FPC_UPC_W-1:0] upc,
  output wire [`FPC_CW_W-1:0]  ctl_word,
  output wire [`FPC_W-1:0]     host_code
);

  // Control word bank; unused fields read as zero
  function [`FPC_CW_W-1:0] cw_rom;
    input [`FPC_UPC_W-1:0] a;
    begin
      cw_rom = {`FPC_CW_W{1'b0}};
      case (a)
        `FPC_U_RD, `FPC_U_RDW, `FPC_U_SYNC, `FPC_U_SVC, `FPC_U_TVEC:
        begin
          cw_rom[`FPC_CW_MIB_DRV] = 1'b1;
        end
        `FPC_U_CMP:
        begin
          cw_rom[`FPC_CW_MIB_DRV] = 1'b1;
          cw_rom[`FPC_CW_FAST]    = 1'b1;
          cw_rom[`FPC_CW_CNT_DEC] = 1'b1;
        end
        `FPC_U_WR, `FPC_U_TRP:
        begin
          cw_rom[`FPC_CW_MIB_DRV] = 1'b1;
          cw_rom[`FPC_CW_DAL_DRV] = 1'b1;
        end
        default:
        begin
          cw_rom = {`FPC_CW_W{1'b0}};
        end
      endcase
    end
  endfunction

  // Host microinstruction bank, one 16-bit word per microaddress
  function [`FPC_W-1:0] hc_rom;
    input [`FPC_UPC_W-1:0] a;
    begin
      case (a)
        `FPC_U_RD:   hc_rom = `FPC_HC_READ;
        `FPC_U_WR:   hc_rom = `FPC_HC_WRITE;
        `FPC_U_SVC:  hc_rom = `FPC_HC_SVC;
        `FPC_U_TRP:  hc_rom = `FPC_HC_TRAP;
        `FPC_U_TVEC: hc_rom = `FPC_TRAP_VEC;
        default:     hc_rom = `FPC_HC_NOP;
      endcase
    end
  endfunction

  // One microaddress selects both words
  assign ctl_word  = cw_rom(upc);
  assign host_code = hc_rom(upc);

endmodule
`default_nettype wire

// >>> src/fpc_defs.vh
// Shared constants for the floating-point coprocessor host attachment
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH
// Bus and word widths
`define FPC_W          16
`define FPC_UPC_W      9
`define FPC_CW_W       104
`define FPC_CNT_W      8
// Microaddresses of the sequencing steps
`define FPC_U_MON      9'h000
`define FPC_U_CAPT     9'h001
`define FPC_U_EX1      9'h002
`define FPC_U_EX2      9'h003
`define FPC_U_DEC      9'h004
`define FPC_U_RD       9'h005
`define FPC_U_RDW      9'h006
`define FPC_U_CMP      9'h007
`define FPC_U_WR       9'h008
`define FPC_U_SYNC     9'h009
`define FPC_U_SVC      9'h00A
`define FPC_U_TRP      9'h00B
`define FPC_U_TVEC     9'h00C
// Host microinstruction codes
`define FPC_HC_FETCH   16'hF001
`define FPC_HC_FPCONF  16'hF002
`define FPC_HC_NOP     16'h0000
`define FPC_HC_READ    16'h2001
`define FPC_HC_WRITE   16'h2002
`define FPC_HC_SVC     16'h3001
`define FPC_HC_TRAP    16'h3002
`define FPC_TRAP_VEC   16'h00A4
// Control word fields
`define FPC_CW_MIB_DRV 0
`define FPC_CW_DAL_DRV 1
`define FPC_CW_FAST    2
`define FPC_CW_CNT_DEC 3
// Instruction fields
`define FPC_OPC_HI     15
`define FPC_OPC_LO     12
`define FPC_FP_CLASS   4'hF
`define FPC_OP_HI      11
`define FPC_OP_LO      8
`define FPC_AC_HI      7
`define FPC_AC_LO      6
`define FPC_SD_HI      5
`define FPC_SD_LO      0
// Transfer sizes and loop steps
`define FPC_WORDS_SGL  8'h02
`define FPC_WORDS_DBL  8'h04
`define FPC_ITER_DEF   8'h08
`define FPC_STEP_NORM  8'h01
`define FPC_STEP_FAST  8'h02
`define FPC_ONE        8'h01
// Flow status bits and format bits
`define FPC_FL_ISFP    0
`define FPC_FL_DBL     1
`define FPC_FL_ERR     2
`define FPC_FL_FAST    3
`define FPC_FMT_FD     0
`define FPC_FMT_FL     1
`endif

// >>> src/fpc_top.v
// Coprocessor attachment: bus monitor, sequencer, host control and transfer logic
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defs.vh"
module fpc_top
#(
  parameter [`FPC_CNT_W-1:0] ITER_COUNT = `FPC_ITER_DEF
)
(
  input  wire                  clk,
  input  wire                  sys_rst,
  input  wire                  host_rst,
  input  wire [`FPC_W-1:0]     micro_instr_bus_i,
  output reg  [`FPC_W-1:0]     micro_instr_bus_o,
  output reg                   micro_instr_bus_oe,
  input  wire [`FPC_W-1:0]     data_addr_lines_i,
  output reg  [`FPC_W-1:0]     data_addr_lines_o,
  output reg                   data_addr_lines_oe,
  output reg                   control_select,
  input  wire                  fmt_double_float,
  input  wire                  fmt_long_int,
  output reg  [1:0]            precision_format_sel,
  output reg  [`FPC_W-1:0]     fp_instr_reg,
  output reg  [`FPC_W-1:0]     dp_operand,
  output reg                   dp_operand_vld,
  output reg                   dp_start,
  output reg                   dp_fast,
  output reg                   dp_result_rd,
  input  wire [`FPC_W-1:0]     dp_result,
  input  wire                  dp_error,
  input  wire [3:0]            dp_fault_code,
  input  wire [3:0]            dp_cond_codes,
  output reg  [3:0]            fault_code_reg,
  output reg  [`FPC_W-1:0]     fault_addr_reg,
  output reg  [3:0]            flow_status_part,
  output reg  [3:0]            cond_code_part,
  output reg  [`FPC_CNT_W-1:0] loop_count,
  output reg                   loop_count_borrow,
  output reg  [`FPC_UPC_W-1:0] micro_pc
);

  // Sequencing steps share codes with the control store addresses
  localparam [`FPC_UPC_W-1:0] S_MON  = `FPC_U_MON;
  localparam [`FPC_UPC_W-1:0] S_CAPT = `FPC_U_CAPT;
  localparam [`FPC_UPC_W-1:0] S_EX1  = `FPC_U_EX1;
  localparam [`FPC_UPC_W-1:0] S_EX2  = `FPC_U_EX2;
  localparam [`FPC_UPC_W-1:0] S_DEC  = `FPC_U_DEC;
  localparam [`FPC_UPC_W-1:0] S_RD   = `FPC_U_RD;
  localparam [`FPC_UPC_W-1:0] S_RDW  = `FPC_U_RDW;
  localparam [`FPC_UPC_W-1:0] S_CMP  = `FPC_U_CMP;
  localparam [`FPC_UPC_W-1:0] S_WR   = `FPC_U_WR;
  localparam [`FPC_UPC_W-1:0] S_SYNC = `FPC_U_SYNC;
  localparam [`FPC_UPC_W-1:0] S_SVC  = `FPC_U_SVC;
  localparam [`FPC_UPC_W-1:0] S_TRP  = `FPC_U_TRP;
  localparam [`FPC_UPC_W-1:0] S_TVEC = `FPC_U_TVEC;

  // Next values
  reg  [`FPC_UPC_W-1:0] upc_d;
  reg                   control_select_d;
  reg  [`FPC_W-1:0]     instr_d;
  reg  [`FPC_W-1:0]     fetch_addr_q;
  reg  [`FPC_W-1:0]     fetch_addr_d;
  reg                   is_fp_q;
  reg                   is_fp_d;
  reg  [1:0]            fmt_d;
  reg  [`FPC_CNT_W-1:0] cnt_d;
  reg  [`FPC_CNT_W-1:0] step;
  reg                   borrow;
  reg  [`FPC_W-1:0]     internal_bus;
  reg                   opv_d;
  reg                   start_d;
  reg                   rrd_d;
  reg  [3:0]            fcode_d;
  reg  [`FPC_W-1:0]     faddr_d;
  reg  [3:0]            flow_d;
  reg  [3:0]            cc_d;
  reg                   force_upc_zero;
  wire [`FPC_CW_W-1:0]  cw_next;
  wire [`FPC_W-1:0]     hc_next;
  wire [`FPC_CW_W-1:0]  cw_now;

  // Words per operand follow the float precision
  function [`FPC_CNT_W-1:0] last_word;
    input dbl;
    begin
      last_word = (dbl ? `FPC_WORDS_DBL : `FPC_WORDS_SGL) - `FPC_ONE;
    end
  endfunction

  // Store is read at the next address so bus outputs can be registered
  fpc_ctl_store u_store_next
  (
    .upc       (upc_d),
    .ctl_word  (cw_next),
    .host_code (hc_next)
  );

  // Current word, for the fast stepping decision
  // Its host code output is not needed here
  fpc_ctl_store u_store_now
  (
    .upc       (micro_pc),
    .ctl_word  (cw_now),
    .host_code ()
  );

  // Fast stepping halves loop time; host bus still gets one code per clock
  always @*
  begin
    step = (dp_fast && cw_now[`FPC_CW_CNT_DEC]) ? `FPC_STEP_FAST : `FPC_STEP_NORM;
    borrow = (loop_count < step);
  end

  // Internal bus source select
  always @*
  begin
    case (micro_pc)
      S_CAPT:  internal_bus = data_addr_lines_i;
      S_RDW:   internal_bus = data_addr_lines_i;
      S_EX2:   internal_bus = {{(`FPC_W-`FPC_CNT_W){1'b0}}, last_word(precision_format_sel[`FPC_FMT_FD])};
      S_WR:    internal_bus = dp_result;
      default: internal_bus = {{(`FPC_W-`FPC_CNT_W){1'b0}}, loop_count};
    endcase
  end

  // Sequencer
  always @*
  begin
    upc_d          = micro_pc;
    control_select_d         = control_select;
    instr_d        = fp_instr_reg;
    fetch_addr_d   = fetch_addr_q;
    is_fp_d        = is_fp_q;
    fmt_d          = precision_format_sel;
    cnt_d          = loop_count;
    opv_d          = 1'b0;
    start_d        = 1'b0;
    rrd_d          = 1'b0;
    fcode_d        = fault_code_reg;
    faddr_d        = fault_addr_reg;
    flow_d         = flow_status_part;
    cc_d           = cond_code_part;
    force_upc_zero = host_rst;
    case (micro_pc)
      S_MON:
      begin
        // Fetch cycle carries the instruction address on the data lines
        if (micro_instr_bus_i == `FPC_HC_FETCH)
        begin
          fetch_addr_d = data_addr_lines_i;
          upc_d        = S_CAPT;
        end
      end
      S_CAPT:
      begin
        instr_d = internal_bus;
        upc_d   = S_EX1;
      end
      S_EX1:
      begin
        // Speculative set-up; left in place, unused, if the host declines
        is_fp_d = (fp_instr_reg[`FPC_OPC_HI:`FPC_OPC_LO] == `FPC_FP_CLASS);
        fmt_d   = {fmt_long_int, fmt_double_float};
        upc_d   = S_EX2;
      end
      S_EX2:
      begin
        cnt_d = internal_bus[`FPC_CNT_W-1:0];
        flow_d[`FPC_FL_ISFP] = is_fp_q;
        flow_d[`FPC_FL_DBL]  = precision_format_sel[`FPC_FMT_FD];
        upc_d = S_DEC;
      end
      S_DEC:
      begin
        if ((micro_instr_bus_i == `FPC_HC_FPCONF) && is_fp_q)
        begin
          control_select_d = 1'b1;
          flow_d[`FPC_FL_ERR] = 1'b0;
          upc_d  = S_RD;
        end
        else
        begin
          force_upc_zero = 1'b1;
        end
      end
      S_RD:
      begin
        upc_d = S_RDW;
      end
      S_RDW:
      begin
        opv_d = 1'b1;
        if (borrow)
        begin
          cnt_d   = ITER_COUNT - `FPC_ONE;
          start_d = 1'b1;
          upc_d   = S_CMP;
        end
        else
        begin
          cnt_d = loop_count - step;
          upc_d = S_RD;
        end
      end
      S_CMP:
      begin
        // Host sees no-operation codes for the whole loop
        if (borrow)
        begin
          cc_d = dp_cond_codes;
          if (dp_error)
          begin
            flow_d[`FPC_FL_ERR] = 1'b1;
            upc_d = S_TRP;
          end
          else
          begin
            cnt_d = last_word(precision_format_sel[`FPC_FMT_FD]);
            rrd_d = 1'b1;
            upc_d = S_WR;
          end
        end
        else
        begin
          cnt_d = loop_count - step;
        end
      end
      S_WR:
      begin
        if (borrow)
        begin
          upc_d = S_SYNC;
        end
        else
        begin
          cnt_d = loop_count - step;
          rrd_d = 1'b1;
        end
      end
      S_SYNC:
      begin
        upc_d = S_SVC;
      end
      S_SVC:
      begin
        control_select_d = 1'b0;
        upc_d  = S_MON;
      end
      S_TRP:
      begin
        fcode_d = dp_fault_code;
        faddr_d = fetch_addr_q;
        upc_d   = S_TVEC;
      end
      S_TVEC:
      begin
        control_select_d = 1'b0;
        upc_d  = S_MON;
      end
      default:
      begin
        force_upc_zero = 1'b1;
      end
    endcase
    if (force_upc_zero)
    begin
      upc_d  = S_MON;
      control_select_d = 1'b0;
    end
  end

  // State and output registers
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      micro_pc             <= S_MON;
      control_select       <= 1'b0;
      micro_instr_bus_o    <= `FPC_HC_NOP;
      micro_instr_bus_oe   <= 1'b0;
      data_addr_lines_o    <= {`FPC_W{1'b0}};
      data_addr_lines_oe   <= 1'b0;
      fp_instr_reg         <= {`FPC_W{1'b0}};
      fetch_addr_q         <= {`FPC_W{1'b0}};
      is_fp_q              <= 1'b0;
      precision_format_sel <= 2'h0;
      loop_count           <= {`FPC_CNT_W{1'b0}};
      loop_count_borrow    <= 1'b0;
      dp_operand           <= {`FPC_W{1'b0}};
      dp_operand_vld       <= 1'b0;
      dp_start             <= 1'b0;
      dp_fast              <= 1'b0;
      dp_result_rd         <= 1'b0;
      fault_code_reg       <= 4'h0;
      fault_addr_reg       <= {`FPC_W{1'b0}};
      flow_status_part     <= 4'h0;
      cond_code_part       <= 4'h0;
    end
    else
    begin
      micro_pc             <= upc_d;
      control_select       <= control_select_d;
      // Drivers only open while in control
      micro_instr_bus_o    <= control_select_d ? hc_next : `FPC_HC_NOP;
      micro_instr_bus_oe   <= control_select_d & cw_next[`FPC_CW_MIB_DRV];
      data_addr_lines_o    <= (upc_d == S_TRP) ? {{(`FPC_W-4){1'b0}}, dp_fault_code} : dp_result;
      data_addr_lines_oe   <= control_select_d & cw_next[`FPC_CW_DAL_DRV];
      fp_instr_reg         <= instr_d;
      fetch_addr_q         <= fetch_addr_d;
      is_fp_q              <= is_fp_d;
      precision_format_sel <= fmt_d;
      loop_count           <= cnt_d;
      loop_count_borrow    <= (cnt_d < `FPC_ONE) ;
      dp_operand           <= opv_d ? internal_bus : dp_operand;
      dp_operand_vld       <= opv_d;
      dp_start             <= start_d;
      dp_fast              <= cw_next[`FPC_CW_FAST];
      dp_result_rd         <= rrd_d;
      fault_code_reg       <= fcode_d;
      fault_addr_reg       <= faddr_d;
      // Fast bit follows the step being entered; the rest comes from sequencing
      flow_status_part     <= {cw_next[`FPC_CW_FAST], flow_d[`FPC_FL_ERR:0]};
      cond_code_part       <= cc_d;
    end
  end

endmodule
`default_nettype wire

// >>> test/fpc_host_model.sv
// Host processor model: drives the host buses and answers coprocessor transfers
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defs.vh"
module fpc_host_model
(
  input  wire logic              clk,
  input  wire logic              clr,
  input  wire logic [`FPC_W-1:0] h_code,
  input  wire logic [`FPC_W-1:0] h_data,
  input  wire logic              ctl,
  input  wire logic [`FPC_W-1:0] mib_o,
  input  wire logic              mib_oe,
  input  wire logic [`FPC_W-1:0] dal_o,
  input  wire logic              dal_oe,
  output logic [`FPC_W-1:0]      mib_i,
  output logic [`FPC_W-1:0]      dal_i
);
  logic [`FPC_W-1:0] dal_q;
  logic [`FPC_W-1:0] trap_word;
  logic [`FPC_W-1:0] wr_word;
  int                n_rd, n_wr, n_svc, n_trap, n_vec;

  // Wire levels; host code also carries the examine and confirm steps
  assign mib_i = mib_oe ? mib_o : h_code;
  assign dal_i = dal_oe ? dal_o : (ctl ? dal_q : h_data);

  // Answer reads with fresh words; idle lines toggle so stale data never looks valid
  always @(posedge clk)
  begin
    if (clr)
    begin
      n_rd <= 0; n_wr <= 0; n_svc <= 0; n_trap <= 0; n_vec <= 0;
      dal_q <= 16'h0000;
    end
    else if (mib_oe)
    begin
      case (mib_o)
        `FPC_HC_READ:
        begin
          dal_q <= 16'h5A00 + n_rd[15:0];
          n_rd <= n_rd + 1;
        end
        `FPC_HC_WRITE:
        begin
          n_wr <= n_wr + (dal_oe ? 1 : 0);
          wr_word <= dal_o; // Last result word written
        end
        `FPC_HC_SVC: n_svc <= n_svc + 1;
        `FPC_HC_TRAP:
        begin
          n_trap <= n_trap + 1;
          trap_word <= dal_o;
        end
        `FPC_TRAP_VEC: n_vec <= n_vec + 1;
        default: dal_q <= ~dal_q;
      endcase
    end
    else
      dal_q <= ~dal_q;
  end
endmodule
`default_nettype wire

// >>> test/fpc_top_bench.sv
// Self-checking bench for the coprocessor host attachment
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defs.vh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module fpc_top_bench;
  logic        clk, sys_rst, host_rst, clr, fmt_double_float, fmt_long_int, dp_error;
  logic        mib_oe, dal_oe, control_select, dp_operand_vld, dp_result_rd, control_select_seen;
  logic        dp_start, dp_fast, loop_count_borrow;
  logic [7:0]  loop_count;
  logic [15:0] h_code, h_data, mib_i, mib_o, dal_i, dal_o, fp_instr_reg;
  logic [15:0] dp_operand, dp_result, fault_addr_reg;
  logic [3:0]  dp_fault_code, dp_cond_codes, fault_code_reg, flow_status_part, cond_code_part;
  logic [1:0]  precision_format_sel;
  logic [8:0]  micro_pc;
  logic [15:0] ops [0:7];
  int          n_ops, n_start, n_fast, errors, n_compared;

  fpc_top #(.ITER_COUNT(8'h04)) i_dut (.clk(clk), .sys_rst(sys_rst), .host_rst(host_rst),
    .micro_instr_bus_i(mib_i), .micro_instr_bus_o(mib_o), .micro_instr_bus_oe(mib_oe),
    .data_addr_lines_i(dal_i), .data_addr_lines_o(dal_o), .data_addr_lines_oe(dal_oe),
    .control_select(control_select), .fmt_double_float(fmt_double_float),
    .fmt_long_int(fmt_long_int), .precision_format_sel(precision_format_sel),
    .fp_instr_reg(fp_instr_reg), .dp_operand(dp_operand), .dp_operand_vld(dp_operand_vld),
    .dp_start(dp_start), .dp_fast(dp_fast), .dp_result_rd(dp_result_rd), .dp_result(dp_result),
    .dp_error(dp_error), .dp_fault_code(dp_fault_code), .dp_cond_codes(dp_cond_codes),
    .fault_code_reg(fault_code_reg), .fault_addr_reg(fault_addr_reg),
    .flow_status_part(flow_status_part), .cond_code_part(cond_code_part),
    .loop_count(loop_count), .loop_count_borrow(loop_count_borrow), .micro_pc(micro_pc));

  fpc_host_model i_host (.clk(clk), .clr(clr), .h_code(h_code), .h_data(h_data),
    .ctl(control_select), .mib_o(mib_o), .mib_oe(mib_oe), .dal_o(dal_o), .dal_oe(dal_oe),
    .mib_i(mib_i), .dal_i(dal_i));

  // Clock at 40 MHz
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Log operands handed to the datapath and any grab of control
  always @(posedge clk)
  begin
    if (clr)
    begin
      n_ops <= 0;
      n_start <= 0;
      n_fast <= 0;
      control_select_seen <= 1'b0;
    end
    else
    begin
      if (dp_operand_vld)
      begin
        ops[n_ops[2:0]] <= dp_operand;
        n_ops <= n_ops + 1;
      end
      if (dp_start)
        n_start <= n_start + 1;
      if (dp_fast)
        n_fast <= n_fast + 1;
      if (control_select)
        control_select_seen <= 1'b1;
    end
  end

  // Result source advances on each word taken
  always @(negedge clk)
    if (sys_rst)
      dp_result <= 16'hC000;
    else if (dp_result_rd)
      dp_result <= dp_result + 16'h0001;

  task cyc(input logic [15:0] c, input logic [15:0] d);
    @(negedge clk);
    h_code = c;
    h_data = d;
  endtask

  // One host instruction: fetch, examine twice, confirm code, then wait for monitor
  task run_instr(input logic [15:0] addr, input logic [15:0] ins, input logic [15:0] conf,
                 input int hr);
    int k;
    cyc(`FPC_HC_NOP, 16'h0000);
    clr = 1'b1;
    cyc(`FPC_HC_FETCH, addr);
    clr = 1'b0;
    cyc(`FPC_HC_NOP, ins);
    cyc(`FPC_HC_NOP, ~ins);
    cyc(`FPC_HC_NOP, ins);
    cyc(conf, 16'h0000);
    k = 0;
    while ((control_select || micro_pc != 9'h000) && k < 200)
    begin
      cyc(`FPC_HC_NOP, 16'h0000);
      host_rst = (k == hr);
      k++;
    end
    host_rst = 1'b0;
    `CHK("back to monitor", 1'b1, k < 200)
  endtask

  task wrap_up;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected hundred or so cycles
  initial
  begin
    #(25 * 4000);
    errors++;
    wrap_up;
  end

  // Main sequence
  initial
  begin
    errors = 0; n_compared = 0; sys_rst = 1'b1; host_rst = 1'b0; clr = 1'b1;
    h_code = 16'h0000; h_data = 16'h0000; fmt_double_float = 1'b0; fmt_long_int = 1'b0;
    dp_error = 1'b0; dp_fault_code = 4'h0; dp_cond_codes = 4'h6;
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    run_instr(16'h1000, 16'h0A55, `FPC_HC_FPCONF, 999);
    `CHK("capture", 16'h0A55, fp_instr_reg)
    `CHK("no control", 1'b0, control_select_seen)
    run_instr(16'h1002, 16'hF123, `FPC_HC_NOP, 999);
    `CHK("host refused", 1'b0, control_select_seen)
    run_instr(16'h1004, 16'hF2C5, `FPC_HC_FPCONF, 999);
    `CHK("took control", 1'b1, control_select_seen)
    `CHK("reads single", 2, i_host.n_rd)
    `CHK("operand 0", 16'h5A00, ops[0])
    `CHK("operand 1", 16'h5A01, ops[1])
    `CHK("writes single", 2, i_host.n_wr)
    `CHK("service", 1, i_host.n_svc)
    `CHK("no trap", 0, i_host.n_trap)
    `CHK("format single", 2'b00, precision_format_sel)
    `CHK("flow single", 3'b001, flow_status_part[2:0])
    `CHK("cond codes", 4'h6, cond_code_part)
    `CHK("instr fields", 16'hF2C5, fp_instr_reg)
    `CHK("start pulse", 1, n_start)
    `CHK("fast steps", 2, n_fast)
    `CHK("loop count", 8'h00, loop_count)
    `CHK("loop borrow", 1'b1, loop_count_borrow)
    `CHK("result word", 16'hC001, i_host.wr_word)
    fmt_double_float = 1'b1; fmt_long_int = 1'b1; dp_error = 1'b1; dp_fault_code = 4'h9;
    run_instr(16'h2468, 16'hF7E1, `FPC_HC_FPCONF, 999);
    `CHK("reads double", 4, i_host.n_rd)
    `CHK("operand 3", 16'h5A03, ops[3])
    `CHK("trap code", 1, i_host.n_trap)
    `CHK("trap vector", 1, i_host.n_vec)
    `CHK("no service", 0, i_host.n_svc)
    `CHK("fault code", 4'h9, fault_code_reg)
    `CHK("fault addr", 16'h2468, fault_addr_reg)
    `CHK("fault word", 16'h0009, i_host.trap_word)
    `CHK("format double", 2'b11, precision_format_sel)
    `CHK("flow double err", 2'b11, flow_status_part[2:1])
    fmt_double_float = 1'b0; fmt_long_int = 1'b0; dp_error = 1'b0;
    run_instr(16'h3000, 16'hF105, `FPC_HC_FPCONF, 2);
    `CHK("reset pc", 9'h000, micro_pc)
    `CHK("reset drivers", 2'b00, {mib_oe, dal_oe})
    `CHK("reset no service", 0, i_host.n_svc)
    run_instr(16'h3002, 16'hF105, `FPC_HC_FPCONF, 999);
    `CHK("recovered", 1, i_host.n_svc)
    wrap_up;
  end
endmodule
`default_nettype wire

// >>> test/fpc_top_chk.sv
// Assertion checker for the coprocessor host attachment
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defs.vh"
module fpc_top_chk
(
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  host_rst,
  input wire logic [`FPC_W-1:0]     micro_instr_bus_i,
  input wire logic [`FPC_W-1:0]     micro_instr_bus_o,
  input wire logic                  micro_instr_bus_oe,
  input wire logic [`FPC_W-1:0]     data_addr_lines_i,
  input wire logic                  data_addr_lines_oe,
  input wire logic                  control_select,
  input wire logic [`FPC_W-1:0]     fp_instr_reg,
  input wire logic [`FPC_UPC_W-1:0] micro_pc
);
  // Host reset is its own rule, so the others stand down while it is high
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || host_rst);

  a_fetch_take: assert property (micro_pc == `FPC_U_MON && micro_instr_bus_i == `FPC_HC_FETCH
    |=> micro_pc == `FPC_U_CAPT) else $error("fetch code not taken");
  a_instr_capt: assert property (micro_pc == `FPC_U_CAPT
    |=> fp_instr_reg == $past(data_addr_lines_i)) else $error("instruction not captured");
  a_exam_two: assert property (micro_pc == `FPC_U_EX1
    |=> micro_pc == `FPC_U_EX2 ##1 micro_pc == `FPC_U_DEC) else $error("exam cycles wrong");
  a_refuse_dec: assert property (micro_pc == `FPC_U_DEC && (micro_instr_bus_i != `FPC_HC_FPCONF
    || fp_instr_reg[15:12] != `FPC_FP_CLASS) |=> micro_pc == `FPC_U_MON && !control_select)
    else $error("refused decode did not return to monitor");
  a_take_ctl: assert property (micro_pc == `FPC_U_DEC && micro_instr_bus_i == `FPC_HC_FPCONF
    && fp_instr_reg[15:12] == `FPC_FP_CLASS |=> control_select && micro_instr_bus_oe)
    else $error("control not taken");
  a_no_contend: assert property ((micro_instr_bus_oe || data_addr_lines_oe) |-> control_select)
    else $error("driver on without control");
  a_read_code: assert property (micro_pc == `FPC_U_RD
    |-> micro_instr_bus_o == `FPC_HC_READ && micro_instr_bus_oe) else $error("read code wrong");
  a_nop_compute: assert property (micro_pc == `FPC_U_CMP |-> micro_instr_bus_o == `FPC_HC_NOP)
    else $error("no-op missing while computing");
  a_svc_return: assert property (micro_pc == `FPC_U_SVC |-> (micro_instr_bus_o == `FPC_HC_SVC)
    ##1 (micro_pc == `FPC_U_MON && !control_select)) else $error("service return wrong");
  a_trap_vec: assert property (micro_pc == `FPC_U_TRP |-> (micro_instr_bus_o == `FPC_HC_TRAP
    && data_addr_lines_oe) ##1 (micro_instr_bus_o == `FPC_TRAP_VEC) ##1 micro_pc == `FPC_U_MON)
    else $error("trap sequence wrong");
  a_host_rst: assert property (disable iff (sys_rst) host_rst
    |=> micro_pc == `FPC_U_MON && !control_select) else $error("host reset ignored");

  // Main paths: success, failure, refusal
  c_service: cover property (micro_pc == `FPC_U_SVC);
  c_trap: cover property (micro_pc == `FPC_U_TRP);
  c_refuse: cover property (micro_pc == `FPC_U_DEC ##1 micro_pc == `FPC_U_MON);
endmodule

bind fpc_top fpc_top_chk i_chk (.clk(clk), .sys_rst(sys_rst), .host_rst(host_rst),
  .micro_instr_bus_i(micro_instr_bus_i), .micro_instr_bus_o(micro_instr_bus_o),
  .micro_instr_bus_oe(micro_instr_bus_oe), .data_addr_lines_i(data_addr_lines_i),
  .data_addr_lines_oe(data_addr_lines_oe), .control_select(control_select),
  .fp_instr_reg(fp_instr_reg), .micro_pc(micro_pc));
`default_nettype wire
